// file: debug_watchpoint_control_test.sv
// bench for the watchpoint control block
`include "dwc_defs.vh"
module debug_watchpoint_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk_in = 1'b0, srst_in = 1'b1, trst_n_in = 1'b1;
    logic        reg_acc_in = 1'b0, reg_rw_in = 1'b0, ext_req = 1'b0;
    logic        irq_in = 1'b0, fiq_in = 1'b0;
    logic [4:0]  reg_addr_in = 5'h00;
    logic [31:0] reg_wdata_in = 32'h0000_0000, av, a1, d1;
    logic [1:0]  ext_cond = 2'b00;
    logic [2:0]  tgt;
    wire  [31:0] ia, id, da, dd, rdata;
    wire  [7:0]  dc;
    wire  [2:0]  st;
    wire  [1:0]  link;
    wire         ca, irq_o, fiq_o, force_o, ack_o, ibrk, dbrk, pabt, dabt, mon;
    int          num_errors = 0, total_checks = 0, cycles = 0;
    dwc_core_model u_core (.core_clk_in(core_clk_in), .i_addr_out(ia), .i_data_out(id),
        .state_out(st), .d_addr_out(da), .d_data_out(dd), .d_ctrl_out(dc), .ack_out(ca));
    dwc_top DUT (.core_clk_in(core_clk_in), .srst_in(srst_in), .trst_n_in(trst_n_in),
        .reg_acc_in(reg_acc_in), .reg_rw_in(reg_rw_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_rdata_out(rdata), .i_addr_in(ia), .i_data_in(id),
        .compressed_state_match_in(st[0]), .bytecode_state_match_in(st[1]),
        .fetch_privilege_match_in(st[2]), .d_addr_in(da), .d_data_in(dd), .d_ctrl_in(dc),
        .external_condition_input_in(ext_cond), .core_halt_ack_in(ca),
        .external_halt_request_in(ext_req), .irq_in(irq_in), .fiq_in(fiq_in),
        .irq_out(irq_o), .fiq_out(fiq_o), .halt_request_force_out(force_o),
        .halt_acknowledge_out(ack_o), .instr_break_signal_out(ibrk), .data_break_out(dbrk),
        .prefetch_abort_out(pabt), .data_abort_out(dabt), .monitor_mode_out(mon),
        .link_latch_output_out(link));
    initial forever #5 core_clk_in = ~core_clk_in;
    task automatic results();
        if (num_errors == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    always @(posedge core_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors++;
            results();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_in);
        #1;
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge core_clk_in);
        {reg_acc_in, reg_rw_in, reg_addr_in, reg_wdata_in} <= {2'b11, a, d};
        @(posedge core_clk_in);
        reg_acc_in <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] exp);
        @(posedge core_clk_in);
        {reg_acc_in, reg_rw_in, reg_addr_in} <= {2'b10, a};
        @(posedge core_clk_in);
        reg_acc_in <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask
    task automatic prog(input logic [4:0] b, input logic [31:0] v, m, dv, dm,
                        input logic [8:0] cv, input logic [7:0] cm);
        wr(b, v);
        wr(b | 5'h01, m);
        wr(b | 5'h02, dv);
        wr(b | 5'h03, dm);
        wr(b | 5'h04, {23'h0, cv});
        wr(b | 5'h05, {24'h0, cm});
    endtask
    task automatic dstep(input logic [31:0] a, input logic [31:0] d, input logic exp);
        u_core.dacc(a, d, 8'h00);
        chk(dbrk, exp);
        u_core.dpark();
    endtask
    task automatic ist(input logic [31:0] a, input logic [2:0] s, input logic e);
        u_core.fetch(a, s);
        chk(ibrk, e);
    endtask
    task automatic dcw(input logic [5:0] v);
        wr(`DWC_ADDR_DBG_CTRL, {26'h0, v});
    endtask
    // enabled instruction-mode control value, targets on bits 1, 2, 4
    function automatic logic [8:0] cv_i(input logic [2:0] t);
        return {1'b1, 3'b000, t[2], 1'b0, t[1], t[0], 1'b0};
    endfunction
    function automatic logic [31:0] dc_read(input logic [31:0] d);
        return d & 32'h0000_0037;
    endfunction
    initial begin
        void'($urandom(32'h4490));
        repeat (6) @(posedge core_clk_in);
        srst_in <= 1'b0;
        rd(`DWC_ADDR_DBG_CTRL, 32'h0000_0010);
        repeat (6) begin
            av = $urandom;
            wr(`DWC_ADDR_DBG_CTRL, av);
            rd(`DWC_ADDR_DBG_CTRL, dc_read(av));
        end
        rd(5'h1f, 32'h0000_0000);
        dcw(6'h00);
        tgt = 3'($urandom_range(7));
        av = $urandom;
        prog(5'h08, av, 32'h0, 32'h0, 32'hffff_ffff, cv_i(tgt), 8'he9);
        for (int s = 0; s < 8; s++) begin
            ist(av, 3'(s), s == tgt);
        end
        ist(av ^ 32'h0000_0100, tgt, 1'b0);
        wr(`DWC_ADDR_WP0_AM, 32'h0000_0100);
        ist(av ^ 32'h0000_0100, tgt, 1'b1);
        dcw(6'h20);
        ist(av, tgt, 1'b0);
        dcw(6'h10);
        u_core.fetch(av, tgt);
        chk({ibrk, pabt}, 2'b01);
        dcw(6'h00);
        wr(`DWC_ADDR_WP0_CV, {23'h0, cv_i(tgt) & 9'h0ff});
        ist(av, tgt, 1'b0);
        wr(`DWC_ADDR_WP0_CV, {23'h0, cv_i(tgt) | 9'h020});
        wr(`DWC_ADDR_WP0_CM, 32'h0000_00c9);
        for (int e = 0; e < 4; e++) begin
            @(posedge core_clk_in);
            ext_cond <= 2'(e);
            cyc(3);
            ist(av, tgt, e % 2 == 1);
        end
        a1 = $urandom;
        d1 = $urandom;
        prog(5'h10, a1, 32'h0, 32'h0, 32'hffff_ffff, 9'h000, 8'hff);
        prog(5'h08, 32'h0, 32'hffff_ffff, 32'h0, 32'hffff_ffff, 9'h180, 8'h7f);
        ist(a1, 3'h0, 1'b1);
        ist(~a1, 3'h0, 1'b0);
        prog(5'h10, a1, 32'h0, d1, 32'h0, 9'h108, 8'hfe);
        prog(5'h08, 32'h0, 32'hffff_ffff, 32'h0, 32'hffff_ffff, 9'h140, 8'hbf);
        dstep(a1, ~d1, 1'b0);
        u_core.fetch(32'h0, 3'h0);
        chk({link[1], ibrk}, 2'b00);
        dstep(a1, d1, 1'b1);
        u_core.fetch(32'h0, 3'h0);
        chk({link[1], ibrk}, 2'b11);
        wr(`DWC_ADDR_WP1_CV, 32'h0000_0108);
        u_core.fetch(32'h0, 3'h0);
        chk({link[1], ibrk}, 2'b00);
        dstep(a1, d1, 1'b1);
        @(posedge core_clk_in);
        trst_n_in <= 1'b0;
        cyc(4);
        chk(link, 2'b00);
        @(posedge core_clk_in);
        {trst_n_in, irq_in, fiq_in} <= 3'b111;
        dcw(6'h04);
        cyc(3);
        chk({irq_o, fiq_o}, 2'b00);
        dcw(6'h01);
        cyc(3);
        chk({ack_o, irq_o, fiq_o}, 3'b100);
        dcw(6'h00);
        cyc(3);
        chk({ack_o, irq_o, fiq_o}, 3'b011);
        u_core.ack(1'b1);
        chk({ack_o, irq_o}, 2'b10);
        u_core.ack(1'b0);
        dcw(6'h02);
        cyc(3);
        chk(force_o, 1'b1);
        dcw(6'h00);
        cyc(3);
        chk(force_o, 1'b0);
        @(posedge core_clk_in);
        ext_req <= 1'b1;
        cyc(3);
        chk(force_o, 1'b1);
        @(posedge core_clk_in);
        {srst_in, ext_req} <= 2'b10;
        cyc(2);
        @(posedge core_clk_in);
        srst_in <= 1'b0;
        rd(`DWC_ADDR_DBG_CTRL, 32'h0000_0010);
        results();
    end
endmodule

// file: dwc_checker.sv
// assertions on the watchpoint control ports
`include "dwc_defs.vh"
module dwc_checker (
    input wire        core_clk_in,
    input wire        srst_in,
    input wire        trst_n_in,
    input wire        reg_acc_in,
    input wire        reg_rw_in,
    input wire [4:0]  reg_addr_in,
    input wire [31:0] reg_wdata_in,
    input wire [31:0] reg_rdata_out,
    input wire        core_halt_ack_in,
    input wire        external_halt_request_in,
    input wire        irq_out,
    input wire        fiq_out,
    input wire        halt_request_force_out,
    input wire        halt_acknowledge_out,
    input wire        instr_break_signal_out,
    input wire        data_break_out,
    input wire        prefetch_abort_out,
    input wire        data_abort_out,
    input wire        monitor_mode_out,
    input wire [1:0]  link_latch_output_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (srst_in);
    wire rd_acc = reg_acc_in && !reg_rw_in;
    wire wr_acc = reg_acc_in && reg_rw_in;
    wire wr_dc  = wr_acc && reg_addr_in == `DWC_ADDR_DBG_CTRL;
    a_ack_merge: assert property (core_halt_ack_in |-> halt_acknowledge_out)
        else $error("ack merge");
    a_int_ack: assert property (halt_acknowledge_out |-> !irq_out && !fiq_out)
        else $error("irq in ack");
    a_int_flag: assert property (wr_dc && reg_wdata_in[2] |=> !irq_out && !fiq_out)
        else $error("irq inhibit");
    a_halt_quiet: assert property (monitor_mode_out |-> !instr_break_signal_out && !data_break_out)
        else $error("halt break");
    a_mon_quiet: assert property (!monitor_mode_out |-> !prefetch_abort_out && !data_abort_out)
        else $error("abort in halt");
    a_mode_write: assert property (wr_dc |=> monitor_mode_out == $past(reg_wdata_in[4]))
        else $error("mode bit");
    a_ext_request: assert property (external_halt_request_in [*3] |-> halt_request_force_out)
        else $error("ext request");
    a_force_req: assert property (wr_dc && reg_wdata_in[1] |-> ##3 halt_request_force_out)
        else $error("force late");
    a_rdata_hold: assert property (!rd_acc |=> $stable(reg_rdata_out))
        else $error("rdata moved");
    a_dc_width: assert property (rd_acc && reg_addr_in == 5'h00 |=>
        reg_rdata_out[31:6] == 26'h000_0000 && !reg_rdata_out[3])
        else $error("dc width");
    a_unmapped_rd: assert property (rd_acc && reg_addr_in == 5'h1f |=> reg_rdata_out == 32'h0000_0000)
        else $error("unmapped read");
    a_cv_clear: assert property (wr_acc && reg_addr_in == `DWC_ADDR_WP1_CV |=>
        !link_latch_output_out[1])
        else $error("link kept");
    a_trst_clear: assert property (!trst_n_in [*4] |-> link_latch_output_out == 2'b00)
        else $error("link in trst");
endmodule
bind dwc_top dwc_checker u_chk (.*);

// file: dwc_core_model.sv
// core-side model: fetch, data bus, acknowledge
module dwc_core_model (
    input  wire         core_clk_in,
    output logic [31:0] i_addr_out,
    output logic [31:0] i_data_out,
    output logic [2:0]  state_out,
    output logic [31:0] d_addr_out,
    output logic [31:0] d_data_out,
    output logic [7:0]  d_ctrl_out,
    output logic        ack_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {i_addr_out, i_data_out, d_addr_out, d_data_out} = 128'h0;
        {state_out, d_ctrl_out, ack_out} = 12'h000;
    end
    task automatic fetch(input logic [31:0] a, input logic [2:0] st);
        @(posedge core_clk_in);
        i_addr_out <= a;
        i_data_out <= a ^ 32'h5a5a_5a5a;
        state_out <= st;
        #1;
    endtask
    task automatic dacc(input logic [31:0] a, d, input logic [7:0] c);
        @(posedge core_clk_in);
        d_addr_out <= a;
        d_data_out <= d;
        d_ctrl_out <= c;
        #1;
    endtask
    // parked bus shows the inverse, never a stale match
    task automatic dpark();
        @(posedge core_clk_in);
        d_addr_out <= ~d_addr_out;
        d_data_out <= ~d_data_out;
        d_ctrl_out <= ~d_ctrl_out;
        #1;
    endtask
    task automatic ack(input logic v);
        @(posedge core_clk_in);
        ack_out <= v;
        #1;
    endtask
endmodule

// file: dwc_defs.vh
// constants for the debug watchpoint control block
`ifndef DWC_DEFS_VH
`define DWC_DEFS_VH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define DWC_ADDR_DBG_CTRL   5'h00
`define DWC_ADDR_WP0_AV     5'h08
`define DWC_ADDR_WP0_AM     5'h09
`define DWC_ADDR_WP0_DV     5'h0a
`define DWC_ADDR_WP0_DM     5'h0b
`define DWC_ADDR_WP0_CV     5'h0c
`define DWC_ADDR_WP0_CM     5'h0d
`define DWC_ADDR_WP1_AV     5'h10
`define DWC_ADDR_WP1_AM     5'h11
`define DWC_ADDR_WP1_DV     5'h12
`define DWC_ADDR_WP1_DM     5'h13
`define DWC_ADDR_WP1_CV     5'h14
`define DWC_ADDR_WP1_CM     5'h15

// ----------------------------------------------------------------
// watchpoint control field positions
// ----------------------------------------------------------------
`define DWC_CV_DIR          0
`define DWC_CV_CMP          1
`define DWC_CV_BYC          2
`define DWC_CV_DSEL         3
`define DWC_CV_PRIV         4
`define DWC_CV_EXT          5
`define DWC_CV_CHAIN        6
`define DWC_CV_RANGE        7
`define DWC_CV_EN           8

// ----------------------------------------------------------------
// debug control fields and reset
// ----------------------------------------------------------------
`define DWC_DC_ACK          0
`define DWC_DC_REQ          1
`define DWC_DC_INTERRUPT_INHIBIT       2
`define DWC_DC_RSVD         3
`define DWC_DC_MON          4
`define DWC_DC_DIS          5
`define DWC_DC_RESET        6'h10
`define DWC_DC_WMASK        6'h37

`define DWC_CV_RESET        9'h000
`define DWC_CM_RESET        8'hff
`define DWC_WORD_RESET      32'h0000_0000
`define DWC_MASK_RESET      32'hffff_ffff

`endif

// file: dwc_top.v
// debug watchpoint control: register chain, two watchpoints, debug control
// Behaviour
// R1: control bit 3 low makes the unit compare instruction-side buses.
// R2: control bit 3 high makes the unit compare data-side buses.
// R3: mask bit one removes the matching value bit from comparison.
// R4: debugger sets control mask bit 0 in instruction mode.
// R5: control bit 1 compares against the compressed-state fetch signal.
// R6: control bit 2 compares against the bytecode-state fetch signal.
// R7: control bit 4 compares against fetch privilege, 1 privileged.
// R8: control bit 5 compares per-unit external condition input, index by unit.
// R9: unit 1 link latch output feeds unit 0 chain input.
// R10: link latch enabled by address or control hit, stores data hit.
// R11: link latch cleared on control value write or test reset low.
// R12: unit 1 address hit feeds unit 0 range input.
// R13: break signal raised on match only when enable bit 8 set.
// R14: debug control is six bits, written when rw high, read when low.
// R15: debug control bit 5 disables comparators; resets to zero.
// R16: reset-set flag keeps comparators off until first chain access.
// R17: debug control bit 4 selects monitor mode, resets to one.
// R18: interrupts inhibited when bit 2 set or acknowledge high.
// R19: bit 1 synchronised then ORed with external halt request.
// R20: visible acknowledge is core acknowledge ORed with bit 0.
// R21: match needs every unmasked address, data and control bit equal.
`include "dwc_defs.vh"

module dwc_top (
    input  wire        core_clk_in,
    input  wire        srst_in,
    input  wire        trst_n_in,
    input  wire        reg_acc_in,
    input  wire        reg_rw_in,
    input  wire [4:0]  reg_addr_in,
    input  wire [31:0] reg_wdata_in,
    output wire [31:0] reg_rdata_out,
    input  wire [31:0] i_addr_in,
    input  wire [31:0] i_data_in,
    input  wire        compressed_state_match_in,
    input  wire        bytecode_state_match_in,
    input  wire        fetch_privilege_match_in,
    input  wire [31:0] d_addr_in,
    input  wire [31:0] d_data_in,
    input  wire [7:0]  d_ctrl_in,
    input  wire [1:0]  external_condition_input_in,
    input  wire        core_halt_ack_in,
    input  wire        external_halt_request_in,
    input  wire        irq_in,
    input  wire        fiq_in,
    output wire        irq_out,
    output wire        fiq_out,
    output wire        halt_request_force_out,
    output wire        halt_acknowledge_out,
    output wire        instr_break_signal_out,
    output wire        data_break_out,
    output wire        prefetch_abort_out,
    output wire        data_abort_out,
    output wire        monitor_mode_out,
    output wire [1:0]  link_latch_output_out
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    reg [1:0] trst_s_r;
    reg [1:0] ereq_s_r;
    reg [1:0] ext_s0_r;
    reg [1:0] ext_s1_r;
    reg [1:0] irq_s_r;
    reg [1:0] fiq_s_r;
    always @(posedge core_clk_in) begin
        if (srst_in) begin
            trst_s_r <= 2'h3;
            ereq_s_r <= 2'h0;
            ext_s0_r <= 2'h0;
            ext_s1_r <= 2'h0;
            irq_s_r  <= 2'h0;
            fiq_s_r  <= 2'h0;
        end else begin
            trst_s_r <= {trst_s_r[0], trst_n_in};
            ereq_s_r <= {ereq_s_r[0], external_halt_request_in};
            ext_s0_r <= {ext_s0_r[0], external_condition_input_in[0]};
            ext_s1_r <= {ext_s1_r[0], external_condition_input_in[1]};
            irq_s_r  <= {irq_s_r[0], irq_in};
            fiq_s_r  <= {fiq_s_r[0], fiq_in};
        end
    end
    wire trst_n = trst_s_r[1];

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    function sel;
        input [4:0] a;
        input [4:0] target;
        begin
            sel = reg_acc_in && reg_rw_in && (a == target);
        end
    endfunction

    reg [5:0]  dbg_ctrl_r;
    reg        cmp_hold_r;
    reg [31:0] av_r [0:1];
    reg [31:0] am_r [0:1];
    reg [31:0] dv_r [0:1];
    reg [31:0] dm_r [0:1];
    reg [8:0]  cv_r [0:1];
    reg [7:0]  cm_r [0:1];
    reg [31:0] rdata_r;

    wire wr_dc = sel(reg_addr_in, `DWC_ADDR_DBG_CTRL); // R14
    wire [1:0] wr_av;
    wire [1:0] wr_am;
    wire [1:0] wr_dv;
    wire [1:0] wr_dm;
    wire [1:0] wr_cv;
    wire [1:0] wr_cm;
    assign wr_av = {sel(reg_addr_in, `DWC_ADDR_WP1_AV), sel(reg_addr_in, `DWC_ADDR_WP0_AV)};
    assign wr_am = {sel(reg_addr_in, `DWC_ADDR_WP1_AM), sel(reg_addr_in, `DWC_ADDR_WP0_AM)};
    assign wr_dv = {sel(reg_addr_in, `DWC_ADDR_WP1_DV), sel(reg_addr_in, `DWC_ADDR_WP0_DV)};
    assign wr_dm = {sel(reg_addr_in, `DWC_ADDR_WP1_DM), sel(reg_addr_in, `DWC_ADDR_WP0_DM)};
    assign wr_cv = {sel(reg_addr_in, `DWC_ADDR_WP1_CV), sel(reg_addr_in, `DWC_ADDR_WP0_CV)};
    assign wr_cm = {sel(reg_addr_in, `DWC_ADDR_WP1_CM), sel(reg_addr_in, `DWC_ADDR_WP0_CM)};

    // ------------------------------------------------------------
    // debug control and power-up hold
    // ------------------------------------------------------------
    always @(posedge core_clk_in) begin
        if (srst_in) begin
            dbg_ctrl_r <= `DWC_DC_RESET; // R15 R17
            cmp_hold_r <= 1'b1; // R16
        end else begin
            if (reg_acc_in) begin
                cmp_hold_r <= 1'b0; // R16
            end
            if (wr_dc) begin
                // reserved bit 3 is kept at zero
                dbg_ctrl_r <= reg_wdata_in[5:0] & `DWC_DC_WMASK; // R14
            end
        end
    end

    // ------------------------------------------------------------
    // watchpoint register banks
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : bank
            always @(posedge core_clk_in) begin
                if (srst_in) begin
                    av_r[g] <= `DWC_WORD_RESET;
                    am_r[g] <= `DWC_MASK_RESET;
                    dv_r[g] <= `DWC_WORD_RESET;
                    dm_r[g] <= `DWC_MASK_RESET;
                    cv_r[g] <= `DWC_CV_RESET;
                    cm_r[g] <= `DWC_CM_RESET;
                end else begin
                    if (wr_av[g]) begin
                        av_r[g] <= reg_wdata_in;
                    end
                    if (wr_am[g]) begin
                        am_r[g] <= reg_wdata_in;
                    end
                    if (wr_dv[g]) begin
                        dv_r[g] <= reg_wdata_in;
                    end
                    if (wr_dm[g]) begin
                        dm_r[g] <= reg_wdata_in;
                    end
                    if (wr_cv[g]) begin
                        cv_r[g] <= reg_wdata_in[8:0];
                    end
                    if (wr_cm[g]) begin
                        cm_r[g] <= reg_wdata_in[7:0];
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    reg [31:0] rdata_nxt;
    always @* begin
        case (reg_addr_in)
            `DWC_ADDR_DBG_CTRL: rdata_nxt = {26'h0, dbg_ctrl_r}; // R14
            `DWC_ADDR_WP0_AV:   rdata_nxt = av_r[0];
            `DWC_ADDR_WP0_AM:   rdata_nxt = am_r[0];
            `DWC_ADDR_WP0_DV:   rdata_nxt = dv_r[0];
            `DWC_ADDR_WP0_DM:   rdata_nxt = dm_r[0];
            `DWC_ADDR_WP0_CV:   rdata_nxt = {23'h0, cv_r[0]};
            `DWC_ADDR_WP0_CM:   rdata_nxt = {24'h0, cm_r[0]};
            `DWC_ADDR_WP1_AV:   rdata_nxt = av_r[1];
            `DWC_ADDR_WP1_AM:   rdata_nxt = am_r[1];
            `DWC_ADDR_WP1_DV:   rdata_nxt = dv_r[1];
            `DWC_ADDR_WP1_DM:   rdata_nxt = dm_r[1];
            `DWC_ADDR_WP1_CV:   rdata_nxt = {23'h0, cv_r[1]};
            `DWC_ADDR_WP1_CM:   rdata_nxt = {24'h0, cm_r[1]};
            default:            rdata_nxt = 32'h0000_0000;
        endcase
    end

    always @(posedge core_clk_in) begin
        if (srst_in) begin
            rdata_r <= 32'h0000_0000;
        end else if (reg_acc_in && !reg_rw_in) begin // R14
            rdata_r <= rdata_nxt;
        end
    end
    assign reg_rdata_out = rdata_r;

    // ------------------------------------------------------------
    // watchpoint units
    // ------------------------------------------------------------
    wire cmp_off = dbg_ctrl_r[`DWC_DC_DIS] | cmp_hold_r; // R15 R16
    // instruction control bus: bit1 compressed, bit2 bytecode, bit4 privilege
    wire [7:0] i_ctrl0 = {2'b00, ext_s0_r[1], fetch_privilege_match_in, 1'b0,
                          bytecode_state_match_in, compressed_state_match_in, 1'b0};
    wire [7:0] i_ctrl1 = {2'b00, ext_s1_r[1], fetch_privilege_match_in, 1'b0,
                          bytecode_state_match_in, compressed_state_match_in, 1'b0};
    // data control bus keeps its bits; bit 5 carries the external condition
    wire [7:0] d_ctrl0 = {d_ctrl_in[7:6], ext_s0_r[1], d_ctrl_in[4:0]}; // R8
    wire [7:0] d_ctrl1 = {d_ctrl_in[7:6], ext_s1_r[1], d_ctrl_in[4:0]}; // R8

    wire [1:0] addr_hit;
    wire [1:0] match;
    wire [1:0] brk;
    wire [1:0] link;

    dwc_unit u_wp1 (
        .core_clk_in           (core_clk_in),
        .srst_in               (srst_in),
        .trst_n_in             (trst_n),
        .cv_wr_in              (wr_cv[1]),
        .addr_val_in           (av_r[1]),
        .addr_mask_in          (am_r[1]),
        .data_val_in           (dv_r[1]),
        .data_mask_in          (dm_r[1]),
        .ctrl_val_in           (cv_r[1]),
        .ctrl_mask_in          (cm_r[1]),
        .cmp_off_in            (cmp_off),
        .i_addr_in             (i_addr_in),
        .i_data_in             (i_data_in),
        .i_ctrl_in             (i_ctrl1),
        .d_addr_in             (d_addr_in),
        .d_data_in             (d_data_in),
        .d_ctrl_in             (d_ctrl1),
        .chain_in              (1'b0),
        .range_in              (1'b0),
        .addr_match_out        (addr_hit[1]),
        .match_out             (match[1]),
        .break_out             (brk[1]),
        .link_latch_output_out (link[1])
    );

    dwc_unit u_wp0 (
        .core_clk_in           (core_clk_in),
        .srst_in               (srst_in),
        .trst_n_in             (trst_n),
        .cv_wr_in              (wr_cv[0]),
        .addr_val_in           (av_r[0]),
        .addr_mask_in          (am_r[0]),
        .data_val_in           (dv_r[0]),
        .data_mask_in          (dm_r[0]),
        .ctrl_val_in           (cv_r[0]),
        .ctrl_mask_in          (cm_r[0]),
        .cmp_off_in            (cmp_off),
        .i_addr_in             (i_addr_in),
        .i_data_in             (i_data_in),
        .i_ctrl_in             (i_ctrl0),
        .d_addr_in             (d_addr_in),
        .d_data_in             (d_data_in),
        .d_ctrl_in             (d_ctrl0),
        .chain_in              (link[1]), // R9
        .range_in              (addr_hit[1]), // R12
        .addr_match_out        (addr_hit[0]),
        .match_out             (match[0]),
        .break_out             (brk[0]),
        .link_latch_output_out (link[0])
    );
    assign link_latch_output_out = link;

    // ------------------------------------------------------------
    // break routing and core-facing signals
    // ------------------------------------------------------------
    wire mon = dbg_ctrl_r[`DWC_DC_MON];
    // unit break goes to the instruction side when it watches fetches
    wire i_brk = (brk[0] & ~cv_r[0][`DWC_CV_DSEL]) | (brk[1] & ~cv_r[1][`DWC_CV_DSEL]);
    wire d_brk = (brk[0] & cv_r[0][`DWC_CV_DSEL]) | (brk[1] & cv_r[1][`DWC_CV_DSEL]);
    assign instr_break_signal_out = i_brk & ~mon; // R13
    assign data_break_out         = d_brk & ~mon;
    assign prefetch_abort_out     = i_brk & mon; // R17
    assign data_abort_out         = d_brk & mon; // R17
    assign monitor_mode_out       = mon;

    // forced request passes two flops before merging with the pin
    reg [1:0] req_s_r;
    always @(posedge core_clk_in) begin
        if (srst_in) begin
            req_s_r <= 2'h0;
        end else begin
            req_s_r <= {req_s_r[0], dbg_ctrl_r[`DWC_DC_REQ]}; // R19
        end
    end
    assign halt_request_force_out = req_s_r[1] | ereq_s_r[1]; // R19

    assign halt_acknowledge_out = core_halt_ack_in | dbg_ctrl_r[`DWC_DC_ACK]; // R20
    wire int_block = dbg_ctrl_r[`DWC_DC_INTERRUPT_INHIBIT] | halt_acknowledge_out; // R18
    assign irq_out = irq_s_r[1] & ~int_block; // R18
    assign fiq_out = fiq_s_r[1] & ~int_block; // R18

endmodule

// file: dwc_unit.v
// one watchpoint comparator unit with its link latch
`include "dwc_defs.vh"

module dwc_unit (
    input  wire        core_clk_in,
    input  wire        srst_in,
    input  wire        trst_n_in,
    input  wire        cv_wr_in,
    input  wire [31:0] addr_val_in,
    input  wire [31:0] addr_mask_in,
    input  wire [31:0] data_val_in,
    input  wire [31:0] data_mask_in,
    input  wire [8:0]  ctrl_val_in,
    input  wire [7:0]  ctrl_mask_in,
    input  wire        cmp_off_in,
    input  wire [31:0] i_addr_in,
    input  wire [31:0] i_data_in,
    input  wire [7:0]  i_ctrl_in,
    input  wire [31:0] d_addr_in,
    input  wire [31:0] d_data_in,
    input  wire [7:0]  d_ctrl_in,
    input  wire        chain_in,
    input  wire        range_in,
    output wire        addr_match_out,
    output wire        match_out,
    output wire        break_out,
    output wire        link_latch_output_out
);

    // ------------------------------------------------------------
    // bus selection
    // ------------------------------------------------------------
    wire        dsel = ctrl_val_in[`DWC_CV_DSEL];
    wire [31:0] a_bus = dsel ? d_addr_in : i_addr_in; // R1 R2
    wire [31:0] v_bus = dsel ? d_data_in : i_data_in; // R1 R2
    wire [7:0]  c_bus = dsel ? d_ctrl_in : i_ctrl_in; // R1 R2

    // ------------------------------------------------------------
    // masked comparison
    // ------------------------------------------------------------
    // control bus layout: bit1 compressed, bit2 bytecode, bit4 privilege,
    // bit5 external, bits 6/7 chain and range
    wire [7:0] c_full = {range_in, chain_in, c_bus[5:0]}; // R5 R6 R7 R8 R9 R12
    // bit 3 selects the bus and is never part of the comparison
    wire [7:0] c_eff_mask = ctrl_mask_in | 8'h08;

    wire a_hit = &((a_bus ~^ addr_val_in) | addr_mask_in); // R3
    wire d_hit = &((v_bus ~^ data_val_in) | data_mask_in); // R3
    wire c_hit = &((c_full ~^ ctrl_val_in[7:0]) | c_eff_mask); // R3

    assign addr_match_out = a_hit & ~cmp_off_in;
    assign match_out      = a_hit & d_hit & c_hit & ~cmp_off_in; // R21
    assign break_out      = match_out & ctrl_val_in[`DWC_CV_EN]; // R13

    // ------------------------------------------------------------
    // link latch
    // ------------------------------------------------------------
    reg link_r;
    always @(posedge core_clk_in) begin
        if (srst_in || cv_wr_in || !trst_n_in) begin // R11
            link_r <= 1'b0;
        end else if ((a_hit | c_hit) && !cmp_off_in) begin // R10
            link_r <= d_hit; // R10
        end
    end
    assign link_latch_output_out = link_r;

endmodule
